// ===== src/eight_bit_compare_timer_regs.svh
`ifndef EIGHT_BIT_COMPARE_TIMER_REGS_SVH
`define EIGHT_BIT_COMPARE_TIMER_REGS_SVH

// Register indexes; byte address is four times the index
`define IDX_SHARED_TIMER_CONTROL 8'h99
`define IDX_TIMER_CONTROL 8'h9A
`define IDX_TIMER_CONTROL_STATUS 8'h9B
`define IDX_MATCH_CONSTANT_A 8'h9C
`define IDX_MATCH_CONSTANT_B 8'h9D
`define IDX_COUNT_REGISTER 8'h9E
`define IDX_IRQ_STATUS 8'hA0
`define IDX_IRQ_CLEAR 8'hA1
`define IDX_IRQ_ENABLE 8'hA2

// timer_control fields
`define TC_CLK_SEL_LSB 0
`define TC_CLEAR_LSB 3
`define TC_OVF_IE_BIT 5
`define TC_MATCH_A_IE_BIT 6
`define TC_MATCH_B_IE_BIT 7

// timer_control_status fields; flags sit in bits 7..5 as {b, a, overflow}
`define TCS_OS_A_LSB 0
`define TCS_OS_B_LSB 2
`define TCS_PWM_BIT 4
`define TCS_FLAG_LSB 5

// shared_timer_control_reg fields
`define STC_EXT_BIT0 0
`define STC_EXT_BIT1 1

// Flag and interrupt status bit order
`define EV_OVF 0
`define EV_MATCH_A 1
`define EV_MATCH_B 2

// Reset values
`define RST_TIMER_CONTROL 8'h00
`define RST_TIMER_CONTROL_STATUS 8'h00
`define RST_MATCH_CONSTANT_A 8'hFF
`define RST_MATCH_CONSTANT_B 8'hFF
`define RST_COUNT_REGISTER 8'h00
`define RST_SHARED_TIMER_CONTROL 8'h00
`define RST_IRQ_ENABLE 8'h00

// Prescaler taps: a tap counts when its bit falls, i.e. clock divided by 2^(tap+1)
`define PRESC_W 11
`define TAP_DIV2 0
`define TAP_DIV512 8
`define TAP_ALT_A 2
`define TAP_ALT_B 10

`endif

// ===== src/eight_bit_compare_timer_pkg.sv
package eight_bit_compare_timer_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    CLK_STOP_LO = 3'h0,
    CLK_SYS = 3'h1,
    CLK_DIV2 = 3'h2,
    CLK_DIV512 = 3'h3,
    CLK_STOP_HI = 3'h4,
    CLK_EXT_RISE = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_BOTH = 3'h7
  } clk_sel_e;

  typedef enum logic [1:0] {
    CLR_NONE = 2'h0,
    CLR_MATCH_A = 2'h1,
    CLR_MATCH_B = 2'h2,
    CLR_EXT_RESET = 2'h3
  } clr_sel_e;

  typedef enum logic [1:0] {
    OUT_KEEP = 2'h0,
    OUT_LOW = 2'h1,
    OUT_HIGH = 2'h2,
    OUT_TOGGLE = 2'h3
  } out_act_e;

endpackage

// ===== src/eight_bit_compare_timer.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "eight_bit_compare_timer_regs.svh"
// Behaviour
// R1 - Clock code 001 counts every system clock, 010 the peripheral clock over 2 and 011 over 512, with two shared bits modifying it.
// R2 - Clock codes 101, 110 and 111 count rising, falling or both edges of the external clock input.
// R3 - Clock codes 000 and 100 give no clock and the counter holds; the code still clears it on an external reset edge with clear field 11.
// R4 - The clear field picks no clear, clear on match A, clear on match B or clear on a rising external reset edge.
// R5 - The overflow request is issued only while the overflow enable bit is 1, which resets to 0.
// R6 - Match request A is issued only while enable bit A is 1, which resets to 0.
// R7 - Match request B is issued only while enable bit B is 1, which resets to 0.
// R8 - The overflow flag sets when the counter wraps from all ones to zero.
// R9 - Match flag A sets when the counter equals match constant A.
// R10 - Match flag B sets when the counter equals match constant B.
// R11 - A flag clears only when software has read it as 1 and then writes 0 to it.
// R12 - Status bits 7 to 5 take only writes of 0 as clears, and a 1 written there does nothing.
// R13 - With all four output select bits at 0 the timer output is disabled.
// R14 - Each output select pair acts on its match: 00 keeps, 01 drives low, 10 drives high, 11 toggles.
// R15 - Each request is high while its flag and enable are both 1 and falls once the flag is cleared.
// R16 - The pulse-width enable bit selects normal mode at 0 and pulse-width output at 1.
module eight_bit_compare_timer
  import eight_bit_compare_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_in,
  input wire logic ext_reset_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic overflow_irq,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic irq
);

  function automatic logic tap_fall(input logic [`PRESC_W-1:0] p, input int b);
    logic r;
    r = 1'b1;
    for (int i = 0; i < `PRESC_W; i++) begin
      if (i <= b) begin
        r = r & p[i];
      end
    end
    return r;
  endfunction

  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    unique case (out_act_e'(act))
      OUT_KEEP: r = cur;
      OUT_LOW: r = 1'b0;
      OUT_HIGH: r = 1'b1;
      OUT_TOGGLE: r = ~cur;
    endcase
    return r;
  endfunction

  byte_t tc_ff, tcs_ctrl_ff, const_a_ff, const_b_ff, cnt_ff;
  logic [1:0] stc_ff;
  logic [2:0] flags_ff, armed_ff, irq_stat_ff, irq_en_ff;
  logic [`PRESC_W-1:0] presc_ff;
  logic ext_clk_s1_ff, ext_clk_s2_ff, ext_clk_s3_ff, ext_clk_lvl_ff;
  logic ext_rst_s1_ff, ext_rst_s2_ff, ext_rst_s3_ff, ext_rst_lvl_ff;
  logic eq_a_prev_ff, eq_b_prev_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, timer_out_ff, timer_out_en_ff;
  logic overflow_irq_ff, match_a_irq_ff, match_b_irq_ff, irq_ff;

  logic [7:0] idx;
  logic addr_ok, setup, done, wr_done, rd_done;
  clk_sel_e clk_sel;
  clr_sel_e clr_sel;
  logic ext_clk_rise, ext_clk_fall, ext_rst_rise, tick;
  logic eq_a, eq_b, hit_a, hit_b, cnt_wr, clear_hit, ovf_evt;
  logic [2:0] events;
  byte_t rd_val;
  byte_t nxt_cnt;
  logic nxt_out;

  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                   ((idx >= `IDX_SHARED_TIMER_CONTROL && idx <= `IDX_COUNT_REGISTER) ||
                    (idx >= `IDX_IRQ_STATUS && idx <= `IDX_IRQ_ENABLE));
  assign setup = psel && !penable;
  assign done = psel && penable && pready_ff;
  assign wr_done = done && pwrite && !pslverr_ff;
  assign rd_done = done && !pwrite && !pslverr_ff;
  assign clk_sel = clk_sel_e'(tc_ff[`TC_CLK_SEL_LSB +: 3]);
  assign clr_sel = clr_sel_e'(tc_ff[`TC_CLEAR_LSB +: 2]);

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      `IDX_SHARED_TIMER_CONTROL: rd_val = {6'h00, stc_ff};
      `IDX_TIMER_CONTROL: rd_val = tc_ff;
      `IDX_TIMER_CONTROL_STATUS: rd_val = {flags_ff, tcs_ctrl_ff[4:0]};
      `IDX_MATCH_CONSTANT_A: rd_val = const_a_ff;
      `IDX_MATCH_CONSTANT_B: rd_val = const_b_ff;
      `IDX_COUNT_REGISTER: rd_val = cnt_ff;
      `IDX_IRQ_STATUS: rd_val = {5'h00, irq_stat_ff};
      `IDX_IRQ_ENABLE: rd_val = {5'h00, irq_en_ff};
      default: rd_val = 8'h00;
    endcase
  end

  // Answer is registered at setup, so each access takes exactly one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !addr_ok;
      prdata_ff <= {24'h00_0000, rd_val};
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc_ff <= `RST_TIMER_CONTROL;
      tcs_ctrl_ff <= `RST_TIMER_CONTROL_STATUS;
      const_a_ff <= `RST_MATCH_CONSTANT_A;
      const_b_ff <= `RST_MATCH_CONSTANT_B;
      stc_ff <= 2'(`RST_SHARED_TIMER_CONTROL);
      irq_en_ff <= 3'(`RST_IRQ_ENABLE);
    end else if (wr_done) begin
      unique case (idx)
        `IDX_SHARED_TIMER_CONTROL: stc_ff <= pwdata[1:0];
        `IDX_TIMER_CONTROL: tc_ff <= pwdata[7:0];
        `IDX_TIMER_CONTROL_STATUS: tcs_ctrl_ff <= {3'h0, pwdata[4:0]};
        `IDX_MATCH_CONSTANT_A: const_a_ff <= pwdata[7:0];
        `IDX_MATCH_CONSTANT_B: const_b_ff <= pwdata[7:0];
        `IDX_IRQ_ENABLE: irq_en_ff <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  // Pin inputs pass three flops; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_s1_ff <= 1'b0;
      ext_clk_s2_ff <= 1'b0;
      ext_clk_s3_ff <= 1'b0;
      ext_clk_lvl_ff <= 1'b0;
      ext_rst_s1_ff <= 1'b0;
      ext_rst_s2_ff <= 1'b0;
      ext_rst_s3_ff <= 1'b0;
      ext_rst_lvl_ff <= 1'b0;
    end else begin
      ext_clk_s1_ff <= ext_clk_in;
      ext_clk_s2_ff <= ext_clk_s1_ff;
      ext_clk_s3_ff <= ext_clk_s2_ff;
      ext_rst_s1_ff <= ext_reset_in;
      ext_rst_s2_ff <= ext_rst_s1_ff;
      ext_rst_s3_ff <= ext_rst_s2_ff;
      if (ext_clk_s2_ff == ext_clk_s3_ff) begin
        ext_clk_lvl_ff <= ext_clk_s3_ff;
      end
      if (ext_rst_s2_ff == ext_rst_s3_ff) begin
        ext_rst_lvl_ff <= ext_rst_s3_ff;
      end
    end
  end

  assign ext_clk_rise = (ext_clk_s2_ff == ext_clk_s3_ff) && ext_clk_s3_ff && !ext_clk_lvl_ff;
  assign ext_clk_fall = (ext_clk_s2_ff == ext_clk_s3_ff) && !ext_clk_s3_ff && ext_clk_lvl_ff;
  assign ext_rst_rise = (ext_rst_s2_ff == ext_rst_s3_ff) && ext_rst_s3_ff && !ext_rst_lvl_ff;

  always_comb begin
    tick = 1'b0;
    unique case (clk_sel)
      CLK_STOP_LO, CLK_STOP_HI: tick = 1'b0; // R3
      CLK_SYS: tick = 1'b1; // R1
      CLK_DIV2: tick = tap_fall(presc_ff, stc_ff[`STC_EXT_BIT0] ? `TAP_ALT_A : `TAP_DIV2); // R1
      CLK_DIV512: tick = tap_fall(presc_ff, stc_ff[`STC_EXT_BIT1] ? `TAP_ALT_B : `TAP_DIV512); // R1
      CLK_EXT_RISE: tick = ext_clk_rise; // R2
      CLK_EXT_FALL: tick = ext_clk_fall; // R2
      CLK_EXT_BOTH: tick = ext_clk_rise || ext_clk_fall; // R2
    endcase
  end

  assign eq_a = (cnt_ff == const_a_ff);
  assign eq_b = (cnt_ff == const_b_ff);
  // Only the start of equality is an event, so a held match does not keep setting a cleared flag
  assign hit_a = eq_a && !eq_a_prev_ff; // R9
  assign hit_b = eq_b && !eq_b_prev_ff; // R10
  assign cnt_wr = wr_done && (idx == `IDX_COUNT_REGISTER);
  assign clear_hit = (clr_sel == CLR_MATCH_A && eq_a) || (clr_sel == CLR_MATCH_B && eq_b); // R4
  assign ovf_evt = tick && !cnt_wr && !(clr_sel == CLR_EXT_RESET && ext_rst_rise) &&
                   !clear_hit && (cnt_ff == 8'hFF); // R8
  assign events = {hit_b, hit_a, ovf_evt};

  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_wr) begin
      nxt_cnt = pwdata[7:0];
    end else if (clr_sel == CLR_EXT_RESET && ext_rst_rise) begin
      nxt_cnt = 8'h00; // R4
    end else if (tick) begin
      nxt_cnt = clear_hit ? 8'h00 : 8'(cnt_ff + 8'h01); // R4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= `RST_COUNT_REGISTER;
      eq_a_prev_ff <= 1'b0;
      eq_b_prev_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      eq_a_prev_ff <= eq_a;
      eq_b_prev_ff <= eq_b;
    end
  end

  // Flags: a read showing 1 arms the clear, a later 0 write clears; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= 3'h0;
      armed_ff <= 3'h0;
    end else begin
      if (wr_done && idx == `IDX_TIMER_CONTROL_STATUS) begin
        flags_ff <= events | (flags_ff & ~(armed_ff & ~pwdata[7:5])); // R11 R12
        armed_ff <= 3'h0;
      end else begin
        flags_ff <= events | flags_ff;
        if (rd_done && idx == `IDX_TIMER_CONTROL_STATUS) begin
          armed_ff <= armed_ff | prdata_ff[7:5]; // R11
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_done && idx == `IDX_IRQ_CLEAR) begin
        irq_stat_ff <= events | (irq_stat_ff & ~pwdata[2:0]);
      end else begin
        irq_stat_ff <= events | irq_stat_ff;
      end
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_ff <= 1'b0;
      match_a_irq_ff <= 1'b0;
      match_b_irq_ff <= 1'b0;
    end else begin
      overflow_irq_ff <= flags_ff[`EV_OVF] && tc_ff[`TC_OVF_IE_BIT]; // R5 R15
      match_a_irq_ff <= flags_ff[`EV_MATCH_A] && tc_ff[`TC_MATCH_A_IE_BIT]; // R6 R15
      match_b_irq_ff <= flags_ff[`EV_MATCH_B] && tc_ff[`TC_MATCH_B_IE_BIT]; // R7 R15
    end
  end

  // Both matches in one cycle: B is applied after A, so B decides on conflict
  always_comb begin
    nxt_out = timer_out_ff;
    if (tcs_ctrl_ff[`TCS_PWM_BIT]) begin
      nxt_out = (cnt_ff < const_a_ff); // R16
    end else begin
      if (hit_a) begin
        nxt_out = apply_act(nxt_out, tcs_ctrl_ff[`TCS_OS_A_LSB +: 2]); // R14
      end
      if (hit_b) begin
        nxt_out = apply_act(nxt_out, tcs_ctrl_ff[`TCS_OS_B_LSB +: 2]); // R14
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_ff <= 1'b0;
      timer_out_en_ff <= 1'b0;
    end else begin
      timer_out_ff <= nxt_out;
      timer_out_en_ff <= |tcs_ctrl_ff[3:0]; // R13
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timer_out = timer_out_ff;
  assign timer_out_en = timer_out_en_ff;
  assign overflow_irq = overflow_irq_ff;
  assign match_a_irq = match_a_irq_ff;
  assign match_b_irq = match_b_irq_ff;
  assign irq = irq_ff;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sys_count;
    clk_sel == CLK_SYS && !cnt_wr && clr_sel == CLR_NONE |=> cnt_ff == 8'($past(cnt_ff) + 8'h01);
  endproperty
  a_sys_count: assert property (p_sys_count) else $error("counter missed a system clock count"); // R1

  property p_ext_rise_count;
    clk_sel == CLK_EXT_RISE && ext_clk_rise && !cnt_wr && clr_sel == CLR_NONE
      |=> cnt_ff == 8'($past(cnt_ff) + 8'h01);
  endproperty
  a_ext_rise_count: assert property (p_ext_rise_count) else $error("external rising edge not counted"); // R2

  property p_stop_holds;
    (clk_sel == CLK_STOP_LO || clk_sel == CLK_STOP_HI) && !cnt_wr && clr_sel != CLR_EXT_RESET |=> $stable(cnt_ff);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped counter changed"); // R3

  property p_ext_clear;
    clr_sel == CLR_EXT_RESET && ext_rst_rise && !cnt_wr |=> cnt_ff == 8'h00;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external reset edge did not clear"); // R4

  property p_ovf_irq_gate;
    !tc_ff[`TC_OVF_IE_BIT] |=> !overflow_irq;
  endproperty
  a_ovf_irq_gate: assert property (p_ovf_irq_gate) else $error("overflow request while disabled"); // R5

  property p_match_a_irq;
    flags_ff[`EV_MATCH_A] && tc_ff[`TC_MATCH_A_IE_BIT] |=> match_a_irq;
  endproperty
  a_match_a_irq: assert property (p_match_a_irq) else $error("match A request missing"); // R6 R15

  property p_match_b_irq;
    !flags_ff[`EV_MATCH_B] |=> !match_b_irq;
  endproperty
  a_match_b_irq: assert property (p_match_b_irq) else $error("match B request without flag"); // R7 R15

  property p_ovf_flag;
    ovf_evt |=> flags_ff[`EV_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set on wrap"); // R8

  property p_match_flags;
    hit_a && hit_b |=> flags_ff[`EV_MATCH_A] && flags_ff[`EV_MATCH_B];
  endproperty
  a_match_flags: assert property (p_match_flags) else $error("match flags not set"); // R9 R10

  property p_clear_needs_read;
    flags_ff[`EV_OVF] && !armed_ff[`EV_OVF] |=> flags_ff[`EV_OVF];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read"); // R11

  property p_write_one_ignored;
    !flags_ff[`EV_MATCH_B] && !hit_b |=> !flags_ff[`EV_MATCH_B];
  endproperty
  a_write_one_ignored: assert property (p_write_one_ignored) else $error("flag set by write"); // R12

  property p_out_disabled;
    tcs_ctrl_ff[3:0] == 4'h0 |=> !timer_out_en;
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("output enabled with no select"); // R13

  property p_toggle_a;
    !tcs_ctrl_ff[`TCS_PWM_BIT] && hit_a && !hit_b && tcs_ctrl_ff[1:0] == 2'h3 |=> timer_out != $past(timer_out);
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("output did not toggle on match A"); // R14

  property p_pwm_level;
    tcs_ctrl_ff[`TCS_PWM_BIT] |=> timer_out == ($past(cnt_ff) < $past(const_a_ff));
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pulse-width output wrong"); // R16

endmodule

// ===== testbench/ext_pins_model.sv
`timescale 1ns/1ps
module ext_pins_model (
  input wire logic pclk,
  output logic ext_clk_in,
  output logic ext_reset_in
);
  // Pins pass three sync flops in the timer, so each level is held 8 clocks
  initial begin
    ext_clk_in = 1'b0;
    ext_reset_in = 1'b0;
  end

  task automatic pulse(input bit on_reset, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (on_reset) begin
        ext_reset_in <= 1'b1;
      end else begin
        ext_clk_in <= 1'b1;
      end
      repeat (8) @(posedge pclk);
      ext_clk_in <= 1'b0;
      ext_reset_in <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule

// ===== testbench/eight_bit_compare_timer_tb.sv
`timescale 1ns/1ps
`include "eight_bit_compare_timer_regs.svh"
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module eight_bit_compare_timer_tb
  import eight_bit_compare_timer_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ext_clk_in, ext_reset_in, timer_out, timer_out_en;
  logic overflow_irq, match_a_irq, match_b_irq, irq;
  int fails, num_checks, cyc;

  eight_bit_compare_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .ext_reset_in(ext_reset_in), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .overflow_irq(overflow_irq), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .irq(irq)
  );
  ext_pins_model u_pins (.pclk(pclk), .ext_clk_in(ext_clk_in), .ext_reset_in(ext_reset_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 12000 clocks
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  // Stopping keeps the enables and clear field so irq outputs stay observable
  task automatic run(input logic [7:0] tc, input int n);
    wr(`IDX_TIMER_CONTROL, tc);
    repeat (n) @(posedge pclk);
    wr(`IDX_TIMER_CONTROL, tc & 8'hF8);
  endtask

  task automatic clrf;
    apb(1'b0, `IDX_TIMER_CONTROL_STATUS, 8'h00);
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    wr(`IDX_IRQ_CLEAR, 8'h07);
  endtask

  task automatic t_reset;
    logic [7:0] idx[6] = '{`IDX_TIMER_CONTROL, `IDX_TIMER_CONTROL_STATUS, `IDX_MATCH_CONSTANT_A,
                           `IDX_MATCH_CONSTANT_B, `IDX_COUNT_REGISTER, `IDX_IRQ_ENABLE};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rdc(idx[i], rv[i]);
    end
    apb(1'b0, 8'h50, 8'h00);
    `CHK({err, rd}, 33'h100000000)
  endtask

  task automatic t_ovf;
    wr(`IDX_COUNT_REGISTER, 8'hFE);
    run({3'b000, CLR_NONE, CLK_SYS}, 10);
    repeat (3) @(posedge pclk);
    `CHK(overflow_irq, 1'b0)
    wr(`IDX_TIMER_CONTROL, 8'h20);
    repeat (3) @(posedge pclk);
    `CHK(overflow_irq, 1'b1)
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    rdc(`IDX_TIMER_CONTROL_STATUS, 8'hE0);
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK(overflow_irq, 1'b0)
    rdc(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    wr(`IDX_TIMER_CONTROL_STATUS, 8'hE0);
    rdc(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    wr(`IDX_IRQ_ENABLE, 8'h07);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(`IDX_IRQ_CLEAR, 8'h07);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    rdc(`IDX_IRQ_STATUS, 8'h00);
  endtask

  task automatic t_ma;
    logic t0;
    wr(`IDX_MATCH_CONSTANT_A, 8'h05);
    wr(`IDX_COUNT_REGISTER, 8'h00);
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h03);
    run({3'b010, CLR_MATCH_A, CLK_SYS}, 40);
    apb(1'b0, `IDX_COUNT_REGISTER, 8'h00);
    `CHK(rd[7:0] <= 8'h05, 1'b1)
    rdc(`IDX_TIMER_CONTROL_STATUS, 8'h43);
    `CHK(match_a_irq, 1'b1)
    `CHK(timer_out_en, 1'b1)
    // Six counts from 4 reach the match exactly once
    t0 = timer_out;
    wr(`IDX_COUNT_REGISTER, 8'h04);
    run({3'b010, CLR_MATCH_A, CLK_SYS}, 3);
    `CHK(timer_out, ~t0)
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK(timer_out_en, 1'b0)
  endtask

  task automatic t_mb;
    logic [1:0] act[2] = '{2'b10, 2'b01};
    clrf();
    wr(`IDX_MATCH_CONSTANT_B, 8'h03);
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_COUNT_REGISTER, 8'h00);
      wr(`IDX_TIMER_CONTROL_STATUS, {4'h0, act[i], 2'b00});
      run({3'b100, CLR_MATCH_B, CLK_SYS}, 20);
      `CHK(timer_out, act[i][1])
      apb(1'b0, `IDX_COUNT_REGISTER, 8'h00);
      `CHK(rd[7:0] <= 8'h03, 1'b1)
      rdc(`IDX_TIMER_CONTROL_STATUS, {4'h8, act[i], 2'b00});
      `CHK(match_b_irq, 1'b1)
    end
  endtask

  task automatic t_ext;
    clk_sel_e sel[5] = '{CLK_EXT_RISE, CLK_EXT_FALL, CLK_EXT_BOTH, CLK_STOP_HI, CLK_STOP_LO};
    logic [7:0] inc[5] = '{8'h03, 8'h03, 8'h06, 8'h00, 8'h00};
    logic [7:0] e = 8'h00;
    clrf();
    wr(`IDX_COUNT_REGISTER, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_TIMER_CONTROL, {5'b00000, sel[i]});
      u_pins.pulse(1'b0, 3);
      repeat (8) @(posedge pclk);
      wr(`IDX_TIMER_CONTROL, 8'h00);
      e = e + inc[i];
      rdc(`IDX_COUNT_REGISTER, e);
    end
    wr(`IDX_TIMER_CONTROL, {3'b000, CLR_EXT_RESET, CLK_STOP_LO});
    u_pins.pulse(1'b1, 1);
    repeat (8) @(posedge pclk);
    rdc(`IDX_COUNT_REGISTER, 8'h00);
  endtask

  task automatic t_pre;
    // Last entry covers the long divider picked by the second shared bit
    logic [7:0] stc[4] = '{8'h00, 8'h00, 8'h01, 8'h02};
    clk_sel_e sel[4] = '{CLK_DIV2, CLK_DIV512, CLK_DIV2, CLK_DIV512};
    int n[4] = '{40, 2100, 80, 6200};
    logic [7:0] lo[4] = '{8'h12, 8'h03, 8'h09, 8'h03};
    logic [7:0] hi[4] = '{8'h17, 8'h05, 8'h0C, 8'h04};
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_SHARED_TIMER_CONTROL, stc[i]);
      wr(`IDX_COUNT_REGISTER, 8'h00);
      run({5'b00000, sel[i]}, n[i]);
      apb(1'b0, `IDX_COUNT_REGISTER, 8'h00);
      `CHK(rd[7:0] >= lo[i] && rd[7:0] <= hi[i], 1'b1)
    end
    wr(`IDX_SHARED_TIMER_CONTROL, 8'h00);
  endtask

  task automatic t_pwm;
    wr(`IDX_MATCH_CONSTANT_A, 8'h80);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    wr(`IDX_TIMER_CONTROL_STATUS, 8'h11);
    wr(`IDX_COUNT_REGISTER, 8'h10);
    repeat (3) @(posedge pclk);
    `CHK(timer_out, 1'b1)
    wr(`IDX_COUNT_REGISTER, 8'h90);
    repeat (3) @(posedge pclk);
    `CHK(timer_out, 1'b0)
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ovf();
    t_ma();
    t_mb();
    t_ext();
    t_pre();
    t_pwm();
    give_verdict();
  end
endmodule
